// ---- design/qni_defines.svh ----
// offsets, field positions, reset values and limits of the queue notify and interrupt block
`ifndef QNI_DEFINES_SVH
`define QNI_DEFINES_SVH

// register byte offsets
`define QNI_OFF_QUEUE_SEL    8'h00
`define QNI_OFF_QUEUE_SIZE   8'h04
`define QNI_OFF_QUEUE_PFN    8'h08
`define QNI_OFF_QUEUE_NOTIFY 8'h0c
`define QNI_OFF_CAUSE        8'h10
`define QNI_OFF_CFG_VECTOR   8'h14
`define QNI_OFF_QUEUE_VECTOR 8'h18
`define QNI_OFF_MSIX_CTRL    8'h1c

// sizes and limits
`define QNI_NUM_QUEUES       4
`define QNI_QSEL_BITS        2
`define QNI_QUEUE_SIZE       16'h0100
`define QNI_PAGE_BYTES       4096
`define QNI_MSIX_TABLE_SIZE  16'h0002
`define QNI_NO_VECTOR        16'hffff
`define QNI_MAX_ENTRY        16'h07ff

// field positions
`define QNI_CAUSE_QUEUE_BIT  0
`define QNI_CAUSE_CFG_BIT    1
`define QNI_MSIX_EN_BIT      0

// reset values
`define QNI_RST_QSEL         16'h0000
`define QNI_RST_PFN          32'h0000_0000
`define QNI_RST_CAUSE        2'h0

`endif

// ---- design/qni_pkg.sv ----
// types of the queue notify and interrupt block
`include "qni_defines.svh"

package qni_pkg;

  typedef struct packed {
    logic [15:0]                          qsel;
    logic [`QNI_NUM_QUEUES-1:0][31:0]     pfn;
    logic [`QNI_NUM_QUEUES-1:0][15:0]     qvec;
    logic [15:0]                          cvec;
    logic                                 msix_en;
    logic [1:0]                           cause;
    logic [`QNI_NUM_QUEUES:0]             pend;
    logic                                 req_v;
    logic [10:0]                          req_vec;
    logic [31:0]                          rdata;
    logic                                 notify_v;
    logic [15:0]                          notify_q;
  } qni_state_t;

endpackage

// ---- design/qni_top.sv ----
// queue doorbell, cause register, legacy interrupt and msi-x vector dispatch behind an apb slave
`timescale 1ns/1ps
`include "qni_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module qni_top (
  // clock and reset
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  // apb slave
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [7:0]                       paddr,
  input  wire logic [31:0]                      pwdata,
  output      logic [31:0]                      prdata,
  output      logic                             pready,
  output      logic                             pslverr,
  // device events
  input  wire logic [`QNI_NUM_QUEUES-1:0]       queue_used_evt,
  input  wire logic                             config_change_evt,
  // doorbell and queue page frame numbers toward the queue engine
  output      logic                             notify_valid,
  output      logic [15:0]                      notify_queue,
  output      logic [`QNI_NUM_QUEUES*32-1:0]    queue_pfn_flat,
  // interrupts
  output      logic                             intx_assert,
  output      logic                             msix_req,
  output      logic [10:0]                      msix_vector,
  input  wire logic                             msix_ack
);

  qni_pkg::qni_state_t st_ff;
  qni_pkg::qni_state_t nxt_st;

  logic setup_phase;
  logic access_phase;
  logic addr_ok;
  logic qsel_ok;

  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign qsel_ok      = (st_ff.qsel < 16'(`QNI_NUM_QUEUES));

  ////////////////////////////////////////////////////////////////////////////////
  // address decode
  always_comb begin
    addr_ok = 1'b0;
    if (paddr[1:0] == 2'h0) begin
      unique case (paddr)
        `QNI_OFF_QUEUE_SEL,
        `QNI_OFF_QUEUE_SIZE,
        `QNI_OFF_QUEUE_PFN,
        `QNI_OFF_QUEUE_NOTIFY,
        `QNI_OFF_CAUSE,
        `QNI_OFF_CFG_VECTOR,
        `QNI_OFF_QUEUE_VECTOR,
        `QNI_OFF_MSIX_CTRL:   addr_ok = 1'b1;
        default:              addr_ok = 1'b0;
      endcase
    end
  end

  // zero wait states; unmapped or unaligned addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access_phase & ~addr_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [31:0]                 rd_mux;
    logic [15:0]                 wvec;
    logic [`QNI_QSEL_BITS-1:0]   qi;
    logic                        found;
    logic                        cause_rd;
    logic [15:0]                 src_vec;
    rd_mux   = 32'h0000_0000;
    wvec     = `QNI_NO_VECTOR;
    qi       = st_ff.qsel[`QNI_QSEL_BITS-1:0];
    found    = 1'b0;
    cause_rd = 1'b0;
    src_vec  = `QNI_NO_VECTOR;
    nxt_st   = st_ff;
    nxt_st.notify_v = 1'b0;

    // read mux, captured in the setup phase so data stands through the access phase
    unique case (paddr)
      `QNI_OFF_QUEUE_SEL:    rd_mux = {16'h0000, st_ff.qsel};
      `QNI_OFF_QUEUE_SIZE:   rd_mux = qsel_ok ? {16'h0000, `QNI_QUEUE_SIZE} : 32'h0000_0000;
      `QNI_OFF_QUEUE_PFN:    rd_mux = qsel_ok ? st_ff.pfn[qi] : 32'h0000_0000;
      `QNI_OFF_CAUSE:        rd_mux = {30'h0000_0000, st_ff.cause};
      `QNI_OFF_CFG_VECTOR:   rd_mux = {16'h0000, st_ff.cvec};
      `QNI_OFF_QUEUE_VECTOR: rd_mux = qsel_ok ? {16'h0000, st_ff.qvec[qi]} : {16'h0000, `QNI_NO_VECTOR};
      `QNI_OFF_MSIX_CTRL:    rd_mux = {31'h0000_0000, st_ff.msix_en};
      default:               rd_mux = 32'h0000_0000;
    endcase
    if (setup_phase & ~pwrite) begin
      nxt_st.rdata = (addr_ok && paddr[1:0] == 2'h0) ? rd_mux : 32'h0000_0000;
    end

    // an out-of-range entry is a mapping failure and reads back as unmapped
    if (pwdata[15:0] < `QNI_MSIX_TABLE_SIZE && pwdata[15:0] <= `QNI_MAX_ENTRY) begin
      wvec = pwdata[15:0];
    end else begin
      wvec = `QNI_NO_VECTOR;
    end

    // register writes take effect at the access edge only
    if (access_phase & pwrite & addr_ok) begin
      unique case (paddr)
        `QNI_OFF_QUEUE_SEL: begin
          nxt_st.qsel = pwdata[15:0];
        end
        `QNI_OFF_QUEUE_PFN: begin
          if (qsel_ok) begin
            nxt_st.pfn[qi] = pwdata;
          end
        end
        `QNI_OFF_QUEUE_NOTIFY: begin
          if (pwdata[15:0] < 16'(`QNI_NUM_QUEUES)) begin
            nxt_st.notify_v = 1'b1;
            nxt_st.notify_q = pwdata[15:0];
          end
        end
        `QNI_OFF_CFG_VECTOR: begin
          nxt_st.cvec = wvec;
        end
        `QNI_OFF_QUEUE_VECTOR: begin
          if (qsel_ok) begin
            nxt_st.qvec[qi] = wvec;
          end
        end
        `QNI_OFF_MSIX_CTRL: begin
          nxt_st.msix_en = pwdata[`QNI_MSIX_EN_BIT];
        end
        default: begin
        end
      endcase
    end

    // clearing read of the cause register; msi-x mode also holds it clear every cycle
    cause_rd = access_phase & ~pwrite & (paddr == `QNI_OFF_CAUSE);
    if (cause_rd) begin
      nxt_st.cause = `QNI_RST_CAUSE;
    end
    if (st_ff.msix_en) begin
      nxt_st.cause = `QNI_RST_CAUSE;
    end

    // msi-x dispatch: finish the outstanding message, then start the lowest pending source
    if (st_ff.req_v & msix_ack) begin
      nxt_st.req_v = 1'b0;
    end
    if (!st_ff.req_v) begin
      for (int i = 0; i <= `QNI_NUM_QUEUES; i++) begin
        // index kept in range so the last pass never reads past the queue mappings
        src_vec = (i == `QNI_NUM_QUEUES) ? st_ff.cvec : st_ff.qvec[i % `QNI_NUM_QUEUES];
        if (!found && st_ff.pend[i]) begin
          found = 1'b1;
          nxt_st.pend[i] = 1'b0;
          // a mapping removed while pending drops the event
          if (src_vec != `QNI_NO_VECTOR) begin
            nxt_st.req_v   = 1'b1;
            nxt_st.req_vec = src_vec[10:0];
          end
        end
      end
    end

    // new events; set after clear so a simultaneous event survives
    for (int i = 0; i < `QNI_NUM_QUEUES; i++) begin
      if (queue_used_evt[i]) begin
        if (!st_ff.msix_en) begin
          nxt_st.cause[`QNI_CAUSE_QUEUE_BIT] = 1'b1;
        end else if (st_ff.qvec[i] != `QNI_NO_VECTOR) begin
          nxt_st.pend[i] = 1'b1;
        end
      end
    end
    if (config_change_evt) begin
      if (!st_ff.msix_en) begin
        nxt_st.cause[`QNI_CAUSE_CFG_BIT] = 1'b1;
      end else if (st_ff.cvec != `QNI_NO_VECTOR) begin
        nxt_st.pend[`QNI_NUM_QUEUES] = 1'b1;
      end
    end

    // leaving msi-x mode discards undelivered messages
    if (!st_ff.msix_en) begin
      nxt_st.pend  = '0;
      nxt_st.req_v = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.qsel     <= `QNI_RST_QSEL;
      st_ff.pfn      <= '0;
      st_ff.qvec     <= {`QNI_NUM_QUEUES{`QNI_NO_VECTOR}};
      st_ff.cvec     <= `QNI_NO_VECTOR;
      st_ff.msix_en  <= 1'b0;
      st_ff.cause    <= `QNI_RST_CAUSE;
      st_ff.pend     <= '0;
      st_ff.req_v    <= 1'b0;
      st_ff.req_vec  <= 11'h000;
      st_ff.rdata    <= 32'h0000_0000;
      st_ff.notify_v <= 1'b0;
      st_ff.notify_q <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata       = st_ff.rdata;
  assign notify_valid = st_ff.notify_v;
  assign notify_queue = st_ff.notify_q;
  assign intx_assert  = |st_ff.cause;
  assign msix_req     = st_ff.req_v;
  assign msix_vector  = st_ff.req_vec;

  for (genvar g = 0; g < `QNI_NUM_QUEUES; g++) begin : g_pfn
    assign queue_pfn_flat[g*32 +: 32] = st_ff.pfn[g];
  end

endmodule // qni_top

// ---- verification/qni_props.sv ----
// concurrent checks of the queue notify and interrupt block at its ports
`timescale 1ns/1ps
`include "qni_defines.svh"
module qni_props (
  input wire logic                       pclk, presetn, psel, penable, pwrite,
  input wire logic [7:0]                 paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [`QNI_NUM_QUEUES-1:0] queue_used_evt,
  input wire logic                       config_change_evt, notify_valid, intx_assert, msix_req, msix_ack,
  input wire logic [15:0]                notify_queue,
  input wire logic [10:0]                msix_vector
);
  logic acc, rdc, wrc, evt, en_ff;
  assign acc = psel && penable;
  assign rdc = acc && !pwrite && paddr == `QNI_OFF_CAUSE;
  assign wrc = acc && pwrite && paddr == `QNI_OFF_MSIX_CTRL;
  assign evt = config_change_evt || (|queue_used_evt);
  // mirror of the msix enable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_ff <= 1'b0;
    else if (wrc) en_ff <= pwdata[`QNI_MSIX_EN_BIT];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_LEGACY_SET: assert property (!en_ff && !wrc && evt |=> intx_assert)
    else $error("legacy event left intx low");
  AST_INTX_HOLD: assert property (intx_assert && !rdc && !wrc |=> intx_assert)
    else $error("intx dropped without a cause read");
  AST_CAUSE_CLR: assert property (rdc && !evt |=> !intx_assert)
    else $error("cause read did not clear intx");
  AST_KEEP_EVT: assert property (rdc && !en_ff && evt |=> intx_assert)
    else $error("event lost during clearing read");
  AST_MSIX_NO_CAUSE: assert property (en_ff && $past(en_ff) |-> !intx_assert)
    else $error("intx raised while msix enabled");
  AST_LEGACY_NO_MSG: assert property (!en_ff |=> !msix_req)
    else $error("msix message while msix disabled");
  AST_MSG_HOLD: assert property (msix_req && !msix_ack && en_ff && !wrc |=> msix_req && $stable(msix_vector))
    else $error("msix message not held");
  AST_MSG_END: assert property (msix_req && msix_ack |=> !msix_req)
    else $error("msix message not ended by ack");
  AST_VEC_RANGE: assert property (msix_req |-> msix_vector < `QNI_MSIX_TABLE_SIZE)
    else $error("msix vector outside table");
  AST_NOTIFY: assert property (acc && pwrite && paddr == `QNI_OFF_QUEUE_NOTIFY && pwdata[15:0] < `QNI_NUM_QUEUES
    |=> notify_valid && notify_queue == $past(pwdata[15:0]))
    else $error("doorbell not passed on");
  AST_NOTIFY_PULSE: assert property (notify_valid |=> !notify_valid)
    else $error("doorbell pulse too long");
  cover property (rdc && evt);
  cover property (msix_req && msix_ack);
  cover property (notify_valid);
endmodule // qni_props

// ---- verification/qni_msix_host.sv ----
// host side taking msi-x messages, acknowledging after a chosen delay
`timescale 1ns/1ps
module qni_msix_host (
  input wire logic       pclk, presetn, msix_req,
  input wire logic [1:0] slow,
  output     logic       msix_ack
);
  logic [1:0] wait_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_ff  <= 2'h0;
      msix_ack <= 1'b0;
    end else begin
      msix_ack <= msix_req && !msix_ack && wait_ff >= slow;
      wait_ff  <= (msix_ack || !msix_req) ? 2'h0 : wait_ff + {1'b0, wait_ff != 2'h3};
    end
  end
endmodule // qni_msix_host

// ---- verification/tb_queue_notify_and_interrupt_logic.sv ----
// self-checking bench of the queue notify and interrupt block
`timescale 1ns/1ps
`include "qni_defines.svh"
module tb_queue_notify_and_interrupt_logic;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, config_change_evt;
  logic notify_valid, intx_assert, msix_req, msix_ack;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, s, d;
  logic [3:0] queue_used_evt;
  logic [15:0] notify_queue;
  logic [10:0] msix_vector;
  logic [127:0] queue_pfn_flat;
  logic [1:0] slow;
  logic [31:0] rq[$], vq[$];
  int n_fail, samples_checked, i, k;
  qni_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .queue_used_evt, .config_change_evt, .notify_valid, .notify_queue, .queue_pfn_flat, .intx_assert,
    .msix_req, .msix_vector, .msix_ack);
  qni_msix_host host (.pclk, .presetn, .msix_req, .slow, .msix_ack);
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task chk(input logic [31:0] v, e);
    samples_checked++;
    if (v !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, v, e);
    end
  endtask
  task summarize;
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one apb transfer; ev pulses events in the access cycle
  task apb(input logic w, input logic [7:0] a, input logic [31:0] dt, input logic [4:0] ev);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, dt};
    @(posedge pclk);
    penable <= 1;
    {config_change_evt, queue_used_evt} <= ev;
    @(posedge pclk);
    for (k = 0; k < 50 && pready !== 1'b1; k++) @(posedge pclk);
    {psel, penable, config_change_evt, queue_used_evt} <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] dt);
    apb(1, a, dt, 0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    apb(0, a, 0, 0);
  endtask
  // pulse events, wait for expected messages, then allow time for strays
  task ev(input logic [4:0] e);
    @(posedge pclk);
    {config_change_evt, queue_used_evt} <= e;
    @(posedge pclk);
    {config_change_evt, queue_used_evt} <= 0;
    for (k = 0; k < 80 && vq.size() != 0; k++) @(posedge pclk);
    repeat (4) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready) chk(prdata, rq.size() ? rq.pop_front() : 32'hdead_beef);
    if (psel && penable) chk({30'h0, pready, pslverr}, {30'h0, 1'b1, paddr == 8'h20});
    if (msix_req && msix_ack) chk({21'h0, msix_vector}, vq.size() ? vq.pop_front() : 32'hdead_beef);
  end
  initial begin
    s = 32'h0000_4c26;
    n_fail = 0;
    samples_checked = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, slow} = 46'h0;
    {queue_used_evt, config_change_evt} = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rd(`QNI_OFF_CFG_VECTOR, 32'h0000_ffff);
    for (i = 0; i < 4; i++) begin
      wr(`QNI_OFF_QUEUE_SEL, i);
      rd(`QNI_OFF_QUEUE_VECTOR, 32'h0000_ffff);
      rd(`QNI_OFF_QUEUE_SIZE, 32'h0000_0100);
      d = rnd();
      wr(`QNI_OFF_QUEUE_PFN, d);
      rd(`QNI_OFF_QUEUE_PFN, d);
      chk(queue_pfn_flat[i*32+:32], d);
      wr(`QNI_OFF_QUEUE_NOTIFY, i);
      #1 chk({16'h0, notify_queue}, i);
    end
    wr(`QNI_OFF_QUEUE_SIZE, 32'h0000_0020);
    rd(`QNI_OFF_QUEUE_SIZE, 32'h0000_0100);
    wr(`QNI_OFF_QUEUE_NOTIFY, 32'h0000_0005);
    #1 chk({16'h0, notify_queue}, 32'h0000_0003);
    ev(5'h04);
    ev(5'h10);
    chk({31'h0, intx_assert}, 32'h1);
    rd(`QNI_OFF_CAUSE, 32'h0000_0003);
    rq.push_back(0);
    apb(0, `QNI_OFF_CAUSE, 0, 5'h01);
    rd(`QNI_OFF_CAUSE, 32'h0000_0001);
    rd(`QNI_OFF_CAUSE, 32'h0000_0000);
    wr(`QNI_OFF_MSIX_CTRL, 32'h0000_0001);
    wr(`QNI_OFF_CFG_VECTOR, 32'h0000_0000);
    wr(`QNI_OFF_QUEUE_SEL, 32'h0000_0001);
    wr(`QNI_OFF_QUEUE_VECTOR, 32'h0000_0001);
    rd(`QNI_OFF_QUEUE_VECTOR, 32'h0000_0001);
    wr(`QNI_OFF_QUEUE_SEL, 32'h0000_0002);
    wr(`QNI_OFF_QUEUE_VECTOR, 32'h0000_0005);
    rd(`QNI_OFF_QUEUE_VECTOR, 32'h0000_ffff);
    for (i = 0; i < 4; i++) begin
      slow <= 2'(rnd());
      vq.push_back(1);
      vq.push_back(0);
      ev(5'h12);
    end
    ev(5'h05);
    rd(`QNI_OFF_CAUSE, 32'h0000_0000);
    wr(`QNI_OFF_CFG_VECTOR, 32'h0000_ffff);
    ev(5'h10);
    rd(8'h20, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    chk(32'(vq.size() + rq.size()), 0);
    summarize;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    summarize;
  end
endmodule // tb_queue_notify_and_interrupt_logic
bind qni_top qni_props props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .queue_used_evt,
  .config_change_evt, .notify_valid, .intx_assert, .msix_req, .msix_ack, .notify_queue, .msix_vector);
